// >>> src/clock_reset_control_map.svh
`ifndef CLOCK_RESET_CONTROL_MAP_SVH
`define CLOCK_RESET_CONTROL_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PCC_OFFSET 8'h00
`define STATUS_OFFSET 8'h04

// ----------------------------------------------------------------
// Power and clock control fields
// ----------------------------------------------------------------
`define PCC_MULT_LSB 0
`define PCC_MULT_MSB 5
`define PCC_DIV_LSB 8
`define PCC_DIV_MSB 9
`define PCC_PIN_CLOCK_BIT 12
`define PCC_MULT_RESET 6'h03
`define PCC_DIV_RESET 2'h0
`define PCC_PIN_CLOCK_RESET 1'b0

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define ST_LOCKED_BIT 0
`define ST_RUNNING_BIT 1
`define ST_RATIO_LSB 2
`define ST_RATIO_MSB 3
`define ST_FROM_PLL_BIT 4

// ----------------------------------------------------------------
// Start-up ratio codes and ratios
// ----------------------------------------------------------------
`define RATIO_CODE_3 2'h0
`define RATIO_CODE_16 2'h1
`define RATIO_CODE_8 2'h2
`define RATIO_CODE_RSVD 2'h3
`define RATIO_3 6'h03
`define RATIO_16 6'h10
`define RATIO_8 6'h08
`define RATIO_DIRECT 6'h01

// ----------------------------------------------------------------
// Timing and defaults
// ----------------------------------------------------------------
`define LOCK_REF_CYCLES 13'h1000
`define RESET_VECTOR_DEFAULT 24'h000000
`define SCAN_WIDTH 8
`define IR_BYPASS 2'h3
`define IR_CAPTURE 2'h1

`endif

// >>> src/clock_reset_control_pkg.sv
package clock_reset_control_pkg;

    // Start-up sequence states
    typedef enum logic [3:0] {
        SEQ_CAPTURE = 4'h1,
        SEQ_LOCK = 4'h2,
        SEQ_FETCH = 4'h4,
        SEQ_RUN = 4'h8
    } seq_state_type;

    // Test access controller states
    typedef enum logic [15:0] {
        TAP_RESET = 16'h0001,
        TAP_IDLE = 16'h0002,
        TAP_SEL_DR = 16'h0004,
        TAP_CAP_DR = 16'h0008,
        TAP_SHIFT_DR = 16'h0010,
        TAP_EXIT1_DR = 16'h0020,
        TAP_PAUSE_DR = 16'h0040,
        TAP_EXIT2_DR = 16'h0080,
        TAP_UPD_DR = 16'h0100,
        TAP_SEL_IR = 16'h0200,
        TAP_CAP_IR = 16'h0400,
        TAP_SHIFT_IR = 16'h0800,
        TAP_EXIT1_IR = 16'h1000,
        TAP_PAUSE_IR = 16'h2000,
        TAP_EXIT2_IR = 16'h4000,
        TAP_UPD_IR = 16'h8000
    } tap_state_type;

    typedef logic [1:0] ratio_code_type;

endpackage

// >>> src/crc_links.sv
`timescale 1ns/1ps
// Lock wait handshake between the sequencer and the lock timer
interface lock_if;
    logic start;
    logic ref_edge;
    logic done;
    modport ctl (output start, output ref_edge, input done);
    modport timer (input start, input ref_edge, output done);
endinterface

// Test port signals between the top and the scan controller
interface tap_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    logic [7:0] capture_bits;
    modport ctl (output tck, output tms, output tdi, output capture_bits, input tdo, input tdo_oe);
    modport tap (input tck, input tms, input tdi, input capture_bits, output tdo, output tdo_oe);
endinterface

// >>> src/lock_timer.sv
`timescale 1ns/1ps
`include "clock_reset_control_map.svh"
module lock_timer (
    input wire logic mclk,
    input wire logic rst_n,
    lock_if.timer lk
);
    import clock_reset_control_pkg::*;

    logic [12:0] count_q;
    logic [12:0] count_d;
    logic done_q;
    wire reached = (count_q == (`LOCK_REF_CYCLES - 13'h0001)) && lk.ref_edge;

    // ----------------------------------------------------------------
    // Count reference edges while the wait is open
    // ----------------------------------------------------------------
    assign count_d = !lk.start ? 13'h0000 : (lk.ref_edge && !done_q) ? count_q + 13'h0001 : count_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 13'h0000;
            done_q <= 1'b0;
        end else begin
            count_q <= count_d;
            done_q <= lk.start && (done_q || reached);
        end
    end

    assign lk.done = done_q;
endmodule

// >>> src/scan_tap.sv
`timescale 1ns/1ps
`include "clock_reset_control_map.svh"
module scan_tap (
    input wire logic mclk,
    input wire logic rst_n,
    tap_if.tap tp
);
    import clock_reset_control_pkg::*;

    tap_state_type state_q;
    tap_state_type state_d;
    logic tck_prev_q;
    logic [1:0] ir_q;
    logic [`SCAN_WIDTH-1:0] scan_q;
    logic bypass_q;
    logic tdo_q;
    logic tdo_oe_q;
    wire tck_rise = tp.tck && !tck_prev_q;
    wire tck_fall = !tp.tck && tck_prev_q;
    wire sel_bypass = (ir_q == `IR_BYPASS);
    wire shifting = (state_q == TAP_SHIFT_DR) || (state_q == TAP_SHIFT_IR);
    wire out_bit = (state_q == TAP_SHIFT_IR) ? ir_q[0] : sel_bypass ? bypass_q : scan_q[0];

    // ----------------------------------------------------------------
    // Controller stepped by the mode select input
    // ----------------------------------------------------------------
    always_comb begin
        unique case (state_q)
            TAP_RESET: state_d = tp.tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: state_d = tp.tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: state_d = tp.tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: state_d = tp.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: state_d = tp.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: state_d = tp.tms ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: state_d = tp.tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: state_d = tp.tms ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: state_d = tp.tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: state_d = tp.tms ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: state_d = tp.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: state_d = tp.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: state_d = tp.tms ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: state_d = tp.tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: state_d = tp.tms ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: state_d = tp.tms ? TAP_SEL_DR : TAP_IDLE;
            default: state_d = TAP_RESET;
        endcase
    end

    // ----------------------------------------------------------------
    // Shift paths advance on the test clock rising edge
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tck_prev_q <= 1'b0;
            state_q <= TAP_RESET;
            ir_q <= `IR_BYPASS;
            scan_q <= '0;
            bypass_q <= 1'b0;
        end else begin
            tck_prev_q <= tp.tck;
            if (tck_rise) begin
                state_q <= state_d;
                if (state_q == TAP_RESET) ir_q <= `IR_BYPASS;
                if (state_q == TAP_CAP_IR) ir_q <= `IR_CAPTURE;
                if (state_q == TAP_SHIFT_IR) ir_q <= {tp.tdi, ir_q[1]};
                if (state_q == TAP_CAP_DR) scan_q <= tp.capture_bits;
                if (state_q == TAP_CAP_DR) bypass_q <= 1'b0;
                if (state_q == TAP_SHIFT_DR && !sel_bypass) scan_q <= {tp.tdi, scan_q[`SCAN_WIDTH-1:1]};
                if (state_q == TAP_SHIFT_DR && sel_bypass) bypass_q <= tp.tdi;
            end
        end
    end

    // Output changes on the falling edge and floats outside shifting
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (tck_fall) begin
            tdo_q <= out_bit;
            tdo_oe_q <= shifting;
        end
    end

    assign tp.tdo = tdo_q;
    assign tp.tdo_oe = tdo_oe_q;
endmodule

// >>> src/clock_reset_control.sv
// Function
// - After reset release, wait 4096 reference clock edges for PLL lock.
// - After lock wait, start fetching at the fixed reset vector address.
// - Bit 12 of control register picks PLL clock or core reset on output.
// - Shared output defaults to reset-out after reset.
// - Reset-out mode presents internal core reset on the shared output.
// - Core clock comes from PLL or directly from reference, per ratio pins.
// - Start-up ratio pins are sampled as the initial clock setting.
// - Multiplier and divider writes change frequency any time after core reset.
// - Mode select input steers the test access state machine.
// - Data in shifts through scan logic; data out floats when not shifting.
// - Ratio codes: 00 is 3:1, 01 is 16:1, 10 is 8:1, 11 reserved.
`timescale 1ns/1ps
`include "clock_reset_control_map.svh"
module clock_reset_control #(
    parameter logic [23:0] RESET_VECTOR = `RESET_VECTOR_DEFAULT
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic reference_clock_in,
    input wire clock_reset_control_pkg::ratio_code_type startup_ratio_select,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic [31:0] reg_rdata,
    output logic crystal_drive_out,
    output logic reset_output,
    output logic core_reset_n,
    output logic core_clock_from_pll,
    output logic [5:0] core_ratio,
    output logic [1:0] core_divider,
    output logic fetch_start,
    output logic [23:0] fetch_address,
    output logic tdo,
    output logic tdo_oe
);
    import clock_reset_control_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Map a start-up ratio code onto a multiplier value
    function automatic logic [5:0] ratio_of(input ratio_code_type code);
        logic [5:0] r;
        r = `RATIO_DIRECT;
        unique case (code)
            `RATIO_CODE_3: r = `RATIO_3;
            `RATIO_CODE_16: r = `RATIO_16;
            `RATIO_CODE_8: r = `RATIO_8;
            `RATIO_CODE_RSVD: r = `RATIO_DIRECT;
        endcase
        return r;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    seq_state_type seq_q;
    seq_state_type seq_d;
    ratio_code_type ratio_code_q;
    logic [5:0] mult_q;
    logic [1:0] div_q;
    logic pin_clock_sel_q;
    logic core_reset_q;
    logic fetch_q;
    logic [23:0] fetch_addr_q;
    logic ref_prev_q;
    logic osc_drive_q;
    logic [7:0] pll_cnt_q;
    logic pll_clk_q;
    logic shared_out_q;
    logic [31:0] rdata_q;

    lock_if lk ();
    tap_if tp ();

    // ----------------------------------------------------------------
    // Register bus decode
    // ----------------------------------------------------------------
    wire hit_pcc = (reg_addr == `PCC_OFFSET);
    wire hit_status = (reg_addr == `STATUS_OFFSET);
    wire core_running = (seq_q == SEQ_FETCH) || (seq_q == SEQ_RUN);
    wire pcc_write = reg_write && hit_pcc;
    wire freq_write = pcc_write && core_running;
    wire from_pll = (ratio_code_q != `RATIO_CODE_RSVD);
    wire ref_edge = reference_clock_in && !ref_prev_q;

    // Read views of both registers
    logic [31:0] pcc_view;
    logic [31:0] status_view;
    always_comb begin
        pcc_view = 32'h00000000;
        pcc_view[`PCC_MULT_MSB:`PCC_MULT_LSB] = mult_q;
        pcc_view[`PCC_DIV_MSB:`PCC_DIV_LSB] = div_q;
        pcc_view[`PCC_PIN_CLOCK_BIT] = pin_clock_sel_q;
        status_view = 32'h00000000;
        status_view[`ST_LOCKED_BIT] = lk.done;
        status_view[`ST_RUNNING_BIT] = core_running;
        status_view[`ST_RATIO_MSB:`ST_RATIO_LSB] = ratio_code_q;
        status_view[`ST_FROM_PLL_BIT] = from_pll;
    end

    wire [31:0] rdata_d = !reg_read ? 32'h00000000 : hit_pcc ? pcc_view : hit_status ? status_view : 32'h00000000;

    // ----------------------------------------------------------------
    // Start-up sequencer
    // ----------------------------------------------------------------
    always_comb begin
        unique case (seq_q)
            SEQ_CAPTURE: seq_d = SEQ_LOCK;
            SEQ_LOCK: seq_d = lk.done ? SEQ_FETCH : SEQ_LOCK;
            SEQ_FETCH: seq_d = SEQ_RUN;
            SEQ_RUN: seq_d = SEQ_RUN;
            default: seq_d = SEQ_CAPTURE;
        endcase
    end

    assign lk.start = (seq_q != SEQ_CAPTURE);
    assign lk.ref_edge = ref_edge;
    wire core_reset_d = !((seq_q == SEQ_LOCK && lk.done) || core_running);

    // Sequencer state and reset release
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            seq_q <= SEQ_CAPTURE;
            core_reset_q <= 1'b1;
            fetch_q <= 1'b0;
            fetch_addr_q <= 24'h000000;
        end else begin
            seq_q <= seq_d;
            core_reset_q <= core_reset_d;
            fetch_q <= (seq_q == SEQ_LOCK) && lk.done;
            if ((seq_q == SEQ_LOCK) && lk.done) fetch_addr_q <= RESET_VECTOR;
        end
    end

    // ----------------------------------------------------------------
    // Clock configuration
    // ----------------------------------------------------------------
    // Ratio pins are caught in the first cycle after reset release
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ratio_code_q <= `RATIO_CODE_3;
            mult_q <= `PCC_MULT_RESET;
            div_q <= `PCC_DIV_RESET;
            pin_clock_sel_q <= `PCC_PIN_CLOCK_RESET;
        end else begin
            if (seq_q == SEQ_CAPTURE) begin
                ratio_code_q <= startup_ratio_select;
                mult_q <= ratio_of(startup_ratio_select);
            end else if (freq_write) begin
                mult_q <= reg_wdata[`PCC_MULT_MSB:`PCC_MULT_LSB];
                div_q <= reg_wdata[`PCC_DIV_MSB:`PCC_DIV_LSB];
            end
            if (pcc_write) pin_clock_sel_q <= reg_wdata[`PCC_PIN_CLOCK_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Oscillator drive and emulated PLL clock
    // ----------------------------------------------------------------
    // The PLL clock half period follows the divider field
    wire [7:0] pll_half = {6'h00, div_q} + 8'h01;
    wire pll_wrap = (pll_cnt_q >= pll_half - 8'h01);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ref_prev_q <= 1'b0;
            osc_drive_q <= 1'b1;
            pll_cnt_q <= 8'h00;
            pll_clk_q <= 1'b0;
        end else begin
            ref_prev_q <= reference_clock_in;
            osc_drive_q <= !reference_clock_in;
            pll_cnt_q <= pll_wrap ? 8'h00 : pll_cnt_q + 8'h01;
            if (pll_wrap) pll_clk_q <= !pll_clk_q;
        end
    end

    // ----------------------------------------------------------------
    // Shared reset/clock output and read data
    // ----------------------------------------------------------------
    // Reset-out takes the next core reset so core and pin release on one edge
    wire shared_out_d = pin_clock_sel_q ? pll_clk_q : !core_reset_d;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shared_out_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            shared_out_q <= shared_out_d;
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // Test access port
    // ----------------------------------------------------------------
    assign tp.tck = tck;
    assign tp.tms = tms;
    assign tp.tdi = tdi;
    assign tp.capture_bits = {startup_ratio_select, shared_out_q, core_reset_q, from_pll, fetch_q, osc_drive_q,
                              reference_clock_in};

    scan_tap u_tap (
        .mclk(mclk),
        .rst_n(rst_n),
        .tp(tp)
    );

    lock_timer u_lock (
        .mclk(mclk),
        .rst_n(rst_n),
        .lk(lk)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_rdata = rdata_q;
    assign crystal_drive_out = osc_drive_q;
    assign reset_output = shared_out_q;
    assign core_reset_n = !core_reset_q;
    assign core_clock_from_pll = from_pll;
    assign core_ratio = mult_q;
    assign core_divider = div_q;
    assign fetch_start = fetch_q;
    assign fetch_address = fetch_addr_q;
    assign tdo = tp.tdo;
    assign tdo_oe = tp.tdo_oe;
endmodule

// >>> bench/clock_reset_control_sva.sv
`timescale 1ns/1ps
module clock_reset_control_sva #(
    parameter logic [23:0] RESET_VECTOR = 24'h000000
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic reference_clock_in,
    input wire clock_reset_control_pkg::ratio_code_type startup_ratio_select,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic [31:0] reg_rdata,
    input wire logic crystal_drive_out,
    input wire logic reset_output,
    input wire logic core_reset_n,
    input wire logic core_clock_from_pll,
    input wire logic [5:0] core_ratio,
    input wire logic [1:0] core_divider,
    input wire logic fetch_start,
    input wire logic [23:0] fetch_address,
    input wire logic tdo,
    input wire logic tdo_oe
);
    import clock_reset_control_pkg::*;
    logic sel_q;
    logic ref_q;
    logic [12:0] edges_q;
    logic [1:0] cyc_q;
    logic [5:0] start_ratio;
    logic ref_edge;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Helper state
    // ----------------------------------------
    // Expected start-up multiplier and reference edge detect
    assign start_ratio = (startup_ratio_select == 2'h0) ? 6'h03 : (startup_ratio_select == 2'h1) ? 6'h10 :
        (startup_ratio_select == 2'h2) ? 6'h08 : 6'h01;
    assign ref_edge = reference_clock_in && !ref_q;
    // Output select copy, edge count and cycles since release
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= 1'b0;
            ref_q <= 1'b1;
            edges_q <= 13'h0000;
            cyc_q <= 2'h0;
        end else begin
            if (reg_write && reg_addr == 8'h00) sel_q <= reg_wdata[12];
            ref_q <= reference_clock_in;
            if (ref_edge && edges_q != 13'h1FFF) edges_q <= edges_q + 13'h0001;
            if (cyc_q != 2'h3) cyc_q <= cyc_q + 2'h1;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    lock_wait_a: assert property ($rose(core_reset_n) |-> edges_q == 13'h1000)
        else $error("core released at wrong lock count");
    start_fetch_a: assert property ($rose(core_reset_n) |-> fetch_start)
        else $error("fetch not started with core release");
    fetch_once_a: assert property (fetch_start |=> !fetch_start && core_reset_n)
        else $error("fetch start not a single pulse");
    fetch_vector_a: assert property (fetch_start |-> fetch_address == RESET_VECTOR)
        else $error("fetch address is not the reset vector");
    reset_mirror_a: assert property (!sel_q && !$past(sel_q) |-> reset_output == core_reset_n)
        else $error("shared pin does not follow core reset");
    ratio_decode_a: assert property (cyc_q == 2'h1 |-> core_ratio == start_ratio)
        else $error("start-up ratio decoded wrongly");
    clock_source_a: assert property (cyc_q == 2'h1 |-> core_clock_from_pll == (startup_ratio_select != 2'h3))
        else $error("core clock source wrong");
    held_ratio_a: assert property (reg_write && reg_addr == 8'h00 && !core_reset_n |=> $stable(core_ratio))
        else $error("multiplier changed while core in reset");
    read_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h00000000)
        else $error("read data outside its cycle");
    scan_float_a: assert property ($changed(tdo_oe) |-> !$past(tck))
        else $error("scan output enable moved outside a falling test clock");
endmodule

bind clock_reset_control clock_reset_control_sva #(.RESET_VECTOR(RESET_VECTOR)) chk_u (
    .mclk(mclk), .rst_n(rst_n), .reference_clock_in(reference_clock_in),
    .startup_ratio_select(startup_ratio_select), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .tck(tck), .tms(tms), .tdi(tdi), .reg_rdata(reg_rdata),
    .crystal_drive_out(crystal_drive_out), .reset_output(reset_output), .core_reset_n(core_reset_n),
    .core_clock_from_pll(core_clock_from_pll), .core_ratio(core_ratio), .core_divider(core_divider),
    .fetch_start(fetch_start), .fetch_address(fetch_address), .tdo(tdo), .tdo_oe(tdo_oe));

// >>> bench/board_source.sv
`timescale 1ns/1ps
module board_source (
    input wire logic mclk,
    input wire logic [3:0] half,
    input wire logic reset_req,
    output logic rst_n,
    output logic reference_clock_in
);
    logic [3:0] cnt_q;
    // Board reset is low from power-up until released
    initial begin
        rst_n = 1'b0;
        reference_clock_in = 1'b0;
        cnt_q = 4'h0;
    end
    // Reference never halts; toggles every half mclk cycles
    always @(posedge mclk) begin
        rst_n <= !reset_req;
        if (cnt_q >= half - 4'h1) begin
            cnt_q <= 4'h0;
            reference_clock_in <= ~reference_clock_in;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

// >>> bench/test_clock_reset_control.sv
`timescale 1ns/1ps
module test_clock_reset_control;
    import clock_reset_control_pkg::*;
    logic mclk, rst_n, reset_req, reference_clock_in, reg_write, reg_read, tck, tms, tdi;
    logic crystal_drive_out, reset_output, core_reset_n, core_clock_from_pll, fetch_start, tdo, tdo_oe;
    logic [3:0] half;
    ratio_code_type startup_ratio_select;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_q;
    logic [5:0] core_ratio, m;
    logic [1:0] core_divider, d;
    logic [23:0] fetch_address;
    logic ref_prev, b, last;
    int fails, compares, seed, cyc, cnt, k, rise_c, fetch_c, rout_c, ticks, toggles;
    clock_reset_control dut (.mclk(mclk), .rst_n(rst_n), .reference_clock_in(reference_clock_in),
        .startup_ratio_select(startup_ratio_select), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .tck(tck), .tms(tms), .tdi(tdi), .reg_rdata(reg_rdata),
        .crystal_drive_out(crystal_drive_out), .reset_output(reset_output), .core_reset_n(core_reset_n),
        .core_clock_from_pll(core_clock_from_pll), .core_ratio(core_ratio), .core_divider(core_divider),
        .fetch_start(fetch_start), .fetch_address(fetch_address), .tdo(tdo), .tdo_oe(tdo_oe));
    board_source src (.mclk(mclk), .half(half), .reset_req(reset_req), .rst_n(rst_n),
        .reference_clock_in(reference_clock_in));
    // ----------------------------------------
    // Clock, timeout and start-up model
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // Cut a hang short
    always @(posedge mclk) begin
        ticks++;
        if (ticks == 70000) begin
            fails++;
            report_and_stop();
        end
    end
    // Count reference edges after release and note when outputs rise
    always @(posedge mclk) begin
        if (!rst_n) begin
            cyc = 0; cnt = 0; k = -10; rise_c = -1; fetch_c = -1; rout_c = -1;
        end else begin
            cyc++;
            if (cyc >= 2 && reference_clock_in && !ref_prev) begin
                cnt++;
                if (cnt == 4096) k = cyc;
            end
            if (core_reset_n === 1'b1 && rise_c < 0) rise_c = cyc;
            if (fetch_start === 1'b1 && fetch_c < 0) fetch_c = cyc;
            if (reset_output === 1'b1 && rout_c < 0) rout_c = cyc;
        end
        ref_prev = reference_clock_in;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chk_time(input int got, input int exp);
        compares++;
        if (got != exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge mclk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1 rd_q = reg_rdata;
    endtask
    task tap_step(input logic s, input logic v);
        @(posedge mclk);
        tms <= s;
        tdi <= v;
        repeat (2) @(posedge mclk);
        tck <= 1'b1;
        repeat (2) @(posedge mclk);
        tck <= 1'b0;
        repeat (4) @(posedge mclk);
        #1;
    endtask
    function automatic int ratio_of(input int c);
        return (c == 0) ? 3 : (c == 1) ? 16 : (c == 2) ? 8 : 1;
    endfunction
    task report_and_stop();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = 3566;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        for (int code = 0; code < 4; code++) begin
            half <= (code == 3) ? 4'h3 : 4'h1;
            startup_ratio_select <= code[1:0];
            reset_req <= 1'b1;
            repeat (6) @(posedge mclk);
            reset_req <= 1'b0;
            repeat (2) @(posedge mclk);
            rd(8'h04);
            chk(rd_q, {27'h0, code != 3, code[1:0], 2'b00});
            chk({26'h0, core_ratio}, ratio_of(code));
            chk({31'h0, core_clock_from_pll}, code != 3);
            m = 6'($random(seed));
            d = 2'($random(seed));
            wr(8'h00, {22'h0, d, 2'h0, m});
            rd(8'h00);
            chk(rd_q, ratio_of(code));
            chk({30'h0, reset_output, core_reset_n}, 32'h0);
            for (int i = 0; i < 30000 && core_reset_n !== 1'b1; i++) @(posedge mclk);
            repeat (3) @(posedge mclk);
            chk_time(rise_c, k + 2);
            chk_time(fetch_c, k + 2);
            chk_time(rout_c, k + 2);
            chk({8'h0, fetch_address}, 32'h0);
            rd(8'h04);
            chk(rd_q, {27'h0, code != 3, code[1:0], 2'b11});
            wr(8'h00, {22'h0, d, 2'h0, m});
            rd(8'h00);
            chk(rd_q, {22'h0, d, 2'h0, m});
            chk({24'h0, core_divider, core_ratio}, {24'h0, d, m});
            wr(8'h00, {19'h0, 1'b1, 2'h0, d, 2'h0, m});
            repeat (2) @(posedge mclk);
            #1 last = reset_output;
            toggles = 0;
            repeat (24) begin
                @(posedge mclk);
                #1 if (reset_output !== last) toggles++;
                last = reset_output;
            end
            chk_time(toggles, 24 / (int'(d) + 1));
            wr(8'h00, {22'h0, d, 2'h0, m});
            repeat (2) @(posedge mclk);
            #1 chk({31'h0, reset_output}, 32'h1);
            chk({31'h0, crystal_drive_out}, {31'h0, !ref_prev});
            rd(8'h10);
            chk(rd_q, 32'h0);
            wr(8'h04, 32'hFFFFFFFF);
            rd(8'h04);
            chk(rd_q, {27'h0, code != 3, code[1:0], 2'b11});
        end
        // Scan port: reset controller, walk to shift in bypass, shift random bits
        chk({31'h0, tdo_oe}, 32'h0);
        repeat (5) tap_step(1'b1, 1'b0);
        tap_step(1'b0, 1'b0);
        tap_step(1'b1, 1'b0);
        tap_step(1'b0, 1'b0);
        tap_step(1'b0, 1'b0);
        chk({30'h0, tdo_oe, tdo}, 32'h2);
        repeat (4) begin
            b = 1'($random(seed));
            tap_step(1'b0, b);
            chk({30'h0, tdo_oe, tdo}, {30'h0, 1'b1, b});
        end
        tap_step(1'b1, 1'b1);
        chk({31'h0, tdo_oe}, 32'h0);
        report_and_stop();
    end
endmodule
